// ---- verilog/ssp_defines.svh ----
// register offsets, field positions, reset values and timing counts of the spi port
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
`define SSP_OFF_BUF       8'h00
`define SSP_OFF_CTL       8'h04
`define SSP_OFF_STAT      8'h08
`define SSP_OFF_AUX       8'h0C
`define SSP_CTL_WRITE_COLLISION_FLAG      7
`define SSP_CTL_OV        6
`define SSP_CTL_EN        5
`define SSP_CTL_CKP       4
`define SSP_STAT_SMP      7
`define SSP_STAT_CKE      6
`define SSP_STAT_BF       0
`define SSP_AUX_DIRA5     8
`define SSP_AUX_IRQEN     9
`define SSP_AUX_IRQF      10
`define SSP_DIRC_SDO      5
`define SSP_DIRC_SCK      3
`define SSP_RST_CTL       8'h00
`define SSP_RST_STAT      8'h00
`define SSP_RST_DIRC      8'hFF
`define SSP_MODE_M4       4'h0
`define SSP_MODE_M16      4'h1
`define SSP_MODE_M64      4'h2
`define SSP_MODE_MTMR     4'h3
`define SSP_MODE_S_SS     4'h4
`define SSP_MODE_S_NOSS   4'h5
`define SSP_FOSC_MHZ      50
`define SSP_HALF_DIV4     6'h02
`define SSP_HALF_DIV16    6'h08
`define SSP_HALF_DIV64    6'h20
`define SSP_LAST_EDGE     4'hF
`define SSP_LAST_BIT      3'h7
`endif

// ---- verilog/ssp_pkg.sv ----
// types shared by the spi port
`default_nettype none
package ssp_pkg;
  typedef enum logic {SSP_IDLE, SSP_RUN} ssp_state_e;
  typedef struct packed {
    logic       write_collision_flag;
    logic       ov;
    logic       en;
    logic       clock_idle_polarity;
    logic [3:0] mode;
  } ssp_ctrl_s;
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic sdo_o;
    logic sdo_oe;
  } ssp_pins_s;
endpackage
`default_nettype wire

// ---- verilog/ssp_spi.sv ----
// spi mode serial port with classic wishbone register access
// Notes on behaviour
// - port works only while port_enable_bit is set; clear, rewrite, set reconfigures
// - input pin self managed; output and clock drivers follow their direction bits
// - bits launch on the programmed edge and are captured on the opposite edge
// - master write to transfer_buffer starts an 8-bit exchange at once
// - master with output disabled still receives bytes with normal status updates
// - data shifts most significant bit first in every mode
// - master clock is system clock over 4, 16, 64 or timer over 2
// - with clock_edge_select set the first bit is valid before the first edge
// - slave shifts on external clock and flags after the eighth capture
// - slave keeps working in sleep and wakes the device on a byte when port interrupts are enabled
// - select controlled slave transfers and drives output only while select is low
// - select going high releases the output pin after the two synchroniser stages, even mid byte
// - select high in controlled mode or enable clear forces bit counter to zero
// - master freezes during sleep and resumes from the same state
// - slave shift register runs without device clocking; here it runs on sys_clk, sampling the synchronised external clock; flag wakes if enabled
// - device reset disables the port and aborts any transfer
// - spi modes map to idle polarity and edge select pairs as tabulated
// - master completion wakes the device only when port interrupts are enabled
// - output pin configured as input sends nothing, allowing two-wire use
// - received byte sets full and irq flags; buffer read clears full flag
// - buffer write during a transfer is dropped and sets write_collision_flag
// - slave byte arriving with buffer full sets overflow and is discarded
// - mode codes 0 to 3 master rates, 4 and 5 slave with and without select
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defines.svh"
module ssp_spi (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             sck_i,
  input  wire logic             sdi_i,
  input  wire logic             ss_n_i,
  input  wire logic             tmr2_match_i,
  input  wire logic             sleep_mode_i,
  output logic                  wake_o,
  output ssp_pkg::ssp_pins_s    pins_o
);
  import ssp_pkg::*;

  // pin synchronisers; the first stage feeds only the second
  logic       sck_m_reg, sck_s_reg, sck_d_reg;
  logic       sdi_m_reg, sdi_s_reg;
  logic       ss_m_reg, ss_s_reg;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sck_m_reg <= 1'b0;
      sck_s_reg <= 1'b0;
      sck_d_reg <= 1'b0;
      sdi_m_reg <= 1'b0;
      sdi_s_reg <= 1'b0;
      ss_m_reg  <= 1'b1;
      ss_s_reg  <= 1'b1;
    end
    else
    begin
      sck_m_reg <= sck_i;
      sck_s_reg <= sck_m_reg;
      sck_d_reg <= sck_s_reg;
      sdi_m_reg <= sdi_i;
      sdi_s_reg <= sdi_m_reg;
      ss_m_reg  <= ss_n_i;
      ss_s_reg  <= ss_m_reg;
    end
  end

  // bus group
  logic        ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  // core group
  ssp_ctrl_s   ctl_reg, ctl_next;
  logic        smp_reg, smp_next, cke_reg, cke_next;
  logic [7:0]  dirc_reg, dirc_next;
  logic        dira5_reg, dira5_next, irqen_reg, irqen_next;
  logic [7:0]  buf_reg, buf_next, shift_reg, shift_next;
  logic        out_reg, out_next, bf_reg, bf_next, irqf_reg, irqf_next;
  ssp_state_e  state_reg, state_next;
  logic [5:0]  div_reg, div_next;
  logic        sck_reg, sck_next;
  logic [3:0]  edge_reg, edge_next;
  logic [2:0]  bits_reg, bits_next;
  logic        cap_reg, cap_next;

  logic bus_req, acc_wr, acc_rd;
  logic is_master, ss_ctl, ss_hold, slave_go, busy;
  logic m_tick, m_to_act, m_tx, m_done;
  logic s_chg, s_to_act, s_tx, s_done;
  logic [5:0] half_cnt;

  assign bus_req   = wb_cyc_i & wb_stb_i & ~ack_reg;
  // effects land on the edge where the master samples ack
  assign acc_wr    = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i;
  assign acc_rd    = wb_cyc_i & wb_stb_i & ack_reg & ~wb_we_i;
  assign is_master = (ctl_reg.mode[3:2] == 2'b00);
  assign ss_ctl    = (ctl_reg.mode == `SSP_MODE_S_SS);
  assign ss_hold   = ss_ctl & ss_s_reg;
  assign slave_go  = ctl_reg.en & ~is_master & ~ss_hold;
  assign busy      = (state_reg == SSP_RUN) | (bits_reg != 3'h0);

  always_comb
  begin
    unique case (ctl_reg.mode[1:0])
      2'b00:   half_cnt = `SSP_HALF_DIV4;
      2'b01:   half_cnt = `SSP_HALF_DIV16;
      default: half_cnt = `SSP_HALF_DIV64;
    endcase
  end

  // sleep gates only the master; the slave keeps running
  assign m_tick = (state_reg == SSP_RUN) & ~sleep_mode_i &
                  ((ctl_reg.mode == `SSP_MODE_MTMR) ? tmr2_match_i :
                   (div_reg == half_cnt - 6'h01));
  assign m_to_act = (sck_reg == ctl_reg.clock_idle_polarity);
  assign m_tx     = (m_to_act == ~cke_reg);
  assign m_done   = m_tick & (edge_reg == `SSP_LAST_EDGE);
  assign s_chg    = slave_go & (sck_s_reg != sck_d_reg);
  assign s_to_act = (sck_d_reg == ctl_reg.clock_idle_polarity);
  assign s_tx     = (s_to_act == ~cke_reg);
  assign s_done   = s_chg & ~s_tx & (bits_reg == `SSP_LAST_BIT);

  always_comb
  begin
    ack_next = bus_req;
    dat_next = 32'h0000_0000;
    if (bus_req)
    begin
      unique case (wb_adr_i)
        `SSP_OFF_BUF:  dat_next = {24'h00_0000, buf_reg};
        `SSP_OFF_CTL:  dat_next = {24'h00_0000, ctl_reg};
        `SSP_OFF_STAT: dat_next = {24'h00_0000, smp_reg, cke_reg, 5'h00, bf_reg};
        `SSP_OFF_AUX:  dat_next = {21'h00_0000, irqf_reg, irqen_reg, dira5_reg, dirc_reg};
        default:       dat_next = 32'h0000_0000;
      endcase
    end
  end

  always_comb
  begin
    ctl_next   = ctl_reg;
    smp_next   = smp_reg;
    cke_next   = cke_reg;
    dirc_next  = dirc_reg;
    dira5_next = dira5_reg;
    irqen_next = irqen_reg;
    buf_next   = buf_reg;
    shift_next = shift_reg;
    out_next   = out_reg;
    bf_next    = bf_reg;
    irqf_next  = irqf_reg;
    state_next = state_reg;
    div_next   = div_reg;
    sck_next   = sck_reg;
    edge_next  = edge_reg;
    bits_next  = bits_reg;
    cap_next   = cap_reg;
    // software side first so that hardware sets below win over clears
    if (acc_wr & wb_sel_i[0])
    begin
      unique case (wb_adr_i)
        `SSP_OFF_BUF:
        begin
          if (busy)
            ctl_next.write_collision_flag = 1'b1;
          else
          begin
            buf_next   = wb_dat_i[7:0];
            shift_next = wb_dat_i[7:0];
            out_next   = wb_dat_i[7];
            if (is_master & ctl_reg.en)
            begin
              state_next = SSP_RUN;
              div_next   = 6'h00;
              edge_next  = 4'h0;
              cap_next   = 1'b0;
            end
          end
        end
        `SSP_OFF_CTL:  ctl_next = wb_dat_i[7:0];
        `SSP_OFF_STAT:
        begin
          smp_next = wb_dat_i[`SSP_STAT_SMP];
          cke_next = wb_dat_i[`SSP_STAT_CKE];
        end
        `SSP_OFF_AUX:  dirc_next = wb_dat_i[7:0];
        default:       ;
      endcase
    end
    if (acc_wr & wb_sel_i[1] & (wb_adr_i == `SSP_OFF_AUX))
    begin
      dira5_next = wb_dat_i[`SSP_AUX_DIRA5];
      irqen_next = wb_dat_i[`SSP_AUX_IRQEN];
      irqf_next  = irqf_reg & wb_dat_i[`SSP_AUX_IRQF];
    end
    if (acc_rd & (wb_adr_i == `SSP_OFF_BUF))
      bf_next = 1'b0;
    // master engine
    if (state_reg == SSP_RUN)
    begin
      if (~sleep_mode_i)
        div_next = m_tick ? 6'h00 : div_reg + 6'h01;
      if (m_tick)
      begin
        sck_next  = ~sck_reg;
        edge_next = edge_reg + 4'h1;
        // the synchronised input trails the pin by two cycles, so a capture
        // is owed and taken at the next launch edge; limitation: at the
        // fastest rate the last bit of an active-edge-launch frame reads early
        if (m_tx)
        begin
          if (cap_reg)
          begin
            shift_next = {shift_reg[6:0], sdi_s_reg};
            out_next   = shift_reg[6];
          end
          else
            out_next = shift_reg[7];
          cap_next = 1'b0;
        end
        else if (m_done)
          shift_next = {shift_reg[6:0], sdi_s_reg};
        else
          cap_next = 1'b1;
        if (m_done)
        begin
          state_next = SSP_IDLE;
          buf_next   = shift_next;
          bf_next    = 1'b1;
          irqf_next  = 1'b1;
        end
      end
    end
    else
      sck_next = ctl_next.clock_idle_polarity;
    // slave engine, paced by the synchronised external clock
    if (s_chg)
    begin
      if (s_tx)
        out_next = shift_reg[7];
      else
      begin
        shift_next = {shift_reg[6:0], sdi_s_reg};
        bits_next  = bits_reg + 3'h1;
      end
      if (s_done)
      begin
        irqf_next = 1'b1;
        if (bf_reg)
          ctl_next.ov = 1'b1;
        else
        begin
          buf_next = shift_next;
          bf_next  = 1'b1;
        end
      end
    end
    // module reset: disabled port or select released
    if (~ctl_reg.en | ss_hold)
    begin
      bits_next  = 3'h0;
      state_next = SSP_IDLE;
      edge_next  = 4'h0;
      div_next   = 6'h00;
      cap_next   = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctl_reg   <= `SSP_RST_CTL;
      smp_reg   <= 1'b0;
      cke_reg   <= 1'b0;
      dirc_reg  <= `SSP_RST_DIRC;
      dira5_reg <= 1'b1;
      irqen_reg <= 1'b0;
      buf_reg   <= 8'h00;
      shift_reg <= 8'h00;
      out_reg   <= 1'b0;
      bf_reg    <= 1'b0;
      irqf_reg  <= 1'b0;
      state_reg <= SSP_IDLE;
      div_reg   <= 6'h00;
      sck_reg   <= 1'b0;
      edge_reg  <= 4'h0;
      bits_reg  <= 3'h0;
      cap_reg   <= 1'b0;
    end
    else
    begin
      ctl_reg   <= ctl_next;
      smp_reg   <= smp_next;
      cke_reg   <= cke_next;
      dirc_reg  <= dirc_next;
      dira5_reg <= dira5_next;
      irqen_reg <= irqen_next;
      buf_reg   <= buf_next;
      shift_reg <= shift_next;
      out_reg   <= out_next;
      bf_reg    <= bf_next;
      irqf_reg  <= irqf_next;
      state_reg <= state_next;
      div_reg   <= div_next;
      sck_reg   <= sck_next;
      edge_reg  <= edge_next;
      bits_reg  <= bits_next;
      cap_reg   <= cap_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign wake_o   = irqf_reg & irqen_reg;
  assign pins_o.sck_o  = sck_reg;
  assign pins_o.sck_oe = ctl_reg.en & is_master & ~dirc_reg[`SSP_DIRC_SCK];
  assign pins_o.sdo_o  = out_reg;
  // select release acts after the two synchroniser stages
  assign pins_o.sdo_oe = ctl_reg.en & ~dirc_reg[`SSP_DIRC_SDO] & ~ss_hold;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_buf_write;
    acc_wr && wb_sel_i[0] && (wb_adr_i == `SSP_OFF_BUF);
  endsequence
  sequence s_master_start;
    s_buf_write ##0 (!busy && is_master && ctl_reg.en);
  endsequence

  a_write_starts: assert property (s_master_start |=> state_reg == SSP_RUN)
    else $error("master write did not start a transfer");
  a_msb_first: assert property (s_master_start |=> pins_o.sdo_o == $past(wb_dat_i[7]))
    else $error("first output bit is not the msb");
  a_collision_set: assert property (s_buf_write ##0 busy |=> ctl_reg.write_collision_flag && $stable(buf_reg))
    else $error("busy write not flagged as collision");
  a_master_done: assert property (m_done |=> bf_reg && irqf_reg && state_reg == SSP_IDLE)
    else $error("master byte completion not reported");
  a_overflow_drop: assert property (s_done && bf_reg |=> ctl_reg.ov && $stable(buf_reg))
    else $error("overflow byte not discarded");
  a_select_release: assert property (ss_ctl && ss_s_reg |-> !pins_o.sdo_oe ##1 bits_reg == 3'h0)
    else $error("select high but output still driven");
  a_disable_reset: assert property (!ctl_reg.en |=> bits_reg == 3'h0 && state_reg == SSP_IDLE)
    else $error("disabled port kept its counters");
  a_sleep_freeze: assert property (state_reg == SSP_RUN && sleep_mode_i |=> $stable(shift_reg) && $stable(sck_reg))
    else $error("master moved during sleep");
  a_wake_gate: assert property (s_done && irqen_reg |=> wake_o)
    else $error("completed slave byte did not wake");
  a_no_wake_masked: assert property (!irqen_reg |-> !wake_o)
    else $error("wake raised with interrupts disabled");
  a_div4_rate: assert property (state_reg == SSP_RUN && ctl_reg.mode == `SSP_MODE_M4 && !sleep_mode_i && m_tick && !m_done ##1 !sleep_mode_i |=> m_tick)
    else $error("divide by four half period wrong");
endmodule
`default_nettype wire

// ---- tb/ssp_peer.sv ----
// behavioural far-end spi slave used while the port is master
`timescale 1ns/1ns
`default_nettype none
module ssp_peer (
  input  wire logic       sck,
  input  wire logic       serial_out_pin,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output logic            serial_in_pin,
  output logic [7:0]      rx_byte
);
  logic [7:0] tx_reg;
  assign serial_in_pin = tx_reg[7];
  // idle low clock: capture on rising, launch on falling
  always @(posedge sck)
    rx_byte <= {rx_byte[6:0], serial_out_pin};
  // fills with inverted bits so a stale line never passes as data
  always @(negedge sck or posedge load)
    if (load)
      tx_reg <= tx_byte;
    else
      tx_reg <= {tx_reg[6:0], ~tx_reg[0]};
endmodule
`default_nettype wire

// ---- tb/ssp_spi_tb.sv ----
// register-level tests of the spi port in master and slave modes
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defines.svh"
module ssp_spi_tb;
  logic               sys_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0]         adr = 0, txd, ptx = 0, prx;
  logic [3:0]         sel = 0;
  logic [31:0]        dat = 0, rdat, q;
  logic               ack, sck_i = 0, ss_n = 1, sbit = 0, slv = 0, psdi;
  logic               tmr = 0, slp = 0, wake, pload = 0;
  ssp_pkg::ssp_pins_s pins;
  int                 bad_count = 0, compares = 0, cyc_cnt = 0, t0, dt, ex;

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    tmr     <= (cyc_cnt % 5 == 0);
  end

  ssp_spi uut (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sck_i(sck_i), .sdi_i(slv ? sbit : psdi), .ss_n_i(ss_n), .tmr2_match_i(tmr),
    .sleep_mode_i(slp), .wake_o(wake), .pins_o(pins)
  );

  ssp_peer peer (
    .sck(pins.sck_o), .serial_out_pin(pins.sdo_o), .load(pload), .tx_byte(ptx),
    .serial_in_pin(psdi), .rx_byte(prx)
  );

  task check(input logic [31:0] got, input logic [31:0] exp);
  begin
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    cyc <= 1;
    stb <= 1;
    we  <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    @(posedge sys_clk);
    while (ack !== 1'b1 && n < 100)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 100)
      bad_count++;
    q = rdat;
    cyc <= 0;
    stb <= 0;
    @(posedge sys_clk);
  endtask

  task finish_test;
  begin
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask

  // slave byte as an external master, mode 0,0: data set before the rising edge
  task automatic sbyte(input logic [7:0] b);
    for (int k = 7; k >= 0; k--)
    begin
      sbit <= b[k];
      repeat (4) @(posedge sys_clk);
      sck_i <= 1;
      repeat (4) @(posedge sys_clk);
      sck_i <= 0;
    end
    repeat (8) @(posedge sys_clk);
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    finish_test;
  end

  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 0;
    wb(0, `SSP_OFF_CTL, 0);
    check(q, 32'h0000_0000);
    wb(0, `SSP_OFF_AUX, 0);
    check(q[7:0], 8'hFF);
    wb(0, 8'h10, 0);
    check(q, 32'h0000_0000);
    wb(1, `SSP_OFF_STAT, 32'h0000_0040);
    for (int i = 0; i < 4; i++)
    begin
      wb(1, `SSP_OFF_AUX, (i == 3) ? 32'h0000_02F7 : 32'h0000_02D7);
      wb(1, `SSP_OFF_CTL, 32'h0000_0020 | i);
      txd = 8'hA5 ^ 8'(i);
      ptx <= 8'h3C + 8'(i);
      pload <= 1;
      @(posedge sys_clk);
      pload <= 0;
      wb(1, `SSP_OFF_BUF, {24'h0, txd});
      t0 = cyc_cnt;
      check(pins.sck_oe, 1'b1);
      wb(1, `SSP_OFF_BUF, 32'h0000_0000);
      dt = 0;
      while (wake !== 1'b1 && dt < 2000)
      begin
        @(posedge sys_clk);
        dt = cyc_cnt - t0;
        slp <= (i == 1 && dt >= 20 && dt < 70);
      end
      ex = (i == 3) ? 80 : (32 << (2 * i)) + ((i == 1) ? 50 : 0);
      check(dt >= ex - 4 && dt <= ex + 4, 1'b1);
      if (i == 3)
        check(pins.sdo_oe, 1'b0);
      else
        check(prx, txd);
      wb(0, `SSP_OFF_STAT, 0);
      check(q[0], 1'b1);
      wb(0, `SSP_OFF_BUF, 0);
      check(q[7:0], 8'h3C + 8'(i));
      wb(0, `SSP_OFF_STAT, 0);
      check(q[0], 1'b0);
      wb(0, `SSP_OFF_CTL, 0);
      check(q[7], 1'b1);
      wb(1, `SSP_OFF_AUX, 32'h0000_04D7);
      check(wake, 1'b0);
      wb(1, `SSP_OFF_CTL, 0);
      check(pins.sck_oe, 1'b0);
      $display("master test %0d done", i);
    end
    // clock already idles low before the slave is enabled
    slv <= 1;
    wb(1, `SSP_OFF_AUX, 32'h0000_02DF);
    wb(1, `SSP_OFF_CTL, 32'h0000_0024);
    ss_n <= 0;
    repeat (4) @(posedge sys_clk);
    check(pins.sdo_oe, 1'b1);
    slp <= 1;
    sbyte(8'h96);
    check(wake, 1'b1);
    sbyte(8'h3B);
    slp <= 0;
    wb(0, `SSP_OFF_CTL, 0);
    check(q[6], 1'b1);
    wb(0, `SSP_OFF_BUF, 0);
    check(q[7:0], 8'h96);
    ss_n <= 1;
    repeat (4) @(posedge sys_clk);
    check(pins.sdo_oe, 1'b0);
    $display("slave test done");
    finish_test;
  end
endmodule
`default_nettype wire
